// ===== src/acc_core.sv
`timescale 1ns/1ps
// Calibration and conversion sequencing back end, clocked by the decimation clock
module acc_core #(
    parameter int CONV_CYC   = 1024, // Conversion time in clock periods
    parameter int DR_CYC     = 256,  // Data rate clock period in clock periods
    parameter int IRQ_HOLD   = 32,   // Auto-clear delay of continuous interrupt
    parameter int FIFO_DEPTH = 2,    // Entries between sampler and multiplier
    parameter int CNT_W      = 16
) (
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    input  wire acc_pkg::acc_spi_t i_spi,
    input  wire logic [23:0]       i_raw_code,
    output logic                   o_sdo,
    output logic                   o_sdo_oe,
    output logic                   o_irq_n,
    output logic                   o_filter_rst,
    output logic [1:0]             o_adc_state
);

    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam logic [CNT_W-1:0] CONV_LEN  = CNT_W'(CONV_CYC - 1);
    localparam logic [CNT_W-1:0] CONV_LEN2 = CNT_W'(2 * CONV_CYC - 1);
    localparam logic [CNT_W-1:0] DR_LEN    = CNT_W'(DR_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LEN  = CNT_W'(IRQ_HOLD - 1);
    localparam logic [PW:0]      FIFO_FULL = (PW + 1)'(FIFO_DEPTH);
    localparam logic [PW-1:0]    PTR_LAST  = PW'(FIFO_DEPTH - 1);

    // ---------------- Serial port ----------------
    acc_pkg::acc_spi_t sy1_q;          // First synchroniser stage
    acc_pkg::acc_spi_t sy2_q;          // Second synchroniser stage
    logic              sck3_q;         // Delayed clock for edge detect
    logic [5:0]        bit_cnt_q;      // Bits seen in this frame
    logic [30:0]       sh_in_q;        // Incoming command and data bits
    logic [23:0]       sh_out_q;       // Outgoing read data
    logic              sdo_q;
    logic              sdo_oe_q;

    wire cs_on     = ~sy2_q.cs_n;
    wire sck_rise  = sy2_q.sck & ~sck3_q;
    wire sck_fall  = ~sy2_q.sck & sck3_q;
    wire [7:0] l_cmd  = {sh_in_q[6:0], sy2_q.sdi};
    wire [3:0] l_adr  = l_cmd[acc_pkg::CMD_ADR_LSB +: 4];
    wire       cmd_at = cs_on & sck_rise & (bit_cnt_q == acc_pkg::CMD_LAST);
    wire       f_end  = cs_on & sck_rise & (bit_cnt_q == acc_pkg::FRAME_LAST);
    wire [7:0] f_cmd  = sh_in_q[30:23];
    wire [3:0] f_adr  = f_cmd[acc_pkg::CMD_ADR_LSB +: 4];
    wire [23:0] f_dat = {sh_in_q[22:0], sy2_q.sdi};
    wire       wr_stb = f_end & (f_cmd[1:0] == acc_pkg::CMD_WR);
    // A full 24-bit read of the result clears a one-shot interrupt
    wire       rd_done = f_end & (f_cmd[1:0] == acc_pkg::CMD_RD) & (f_adr == acc_pkg::ADR_RESULT);

    // ---------------- Registers ----------------
    logic [23:0] result_q;             // Conversion result
    logic [23:0] offset_q;             // Offset correction
    logic [23:0] gain_q;               // Gain correction
    logic [7:0]  config_q;             // Config word three
    logic [1:0]  adc_state_q;          // Converter state field

    wire [1:0] conversion_mode_select = config_q[acc_pkg::CFG_CMODE +: 2];
    wire       az_on     = config_q[acc_pkg::CFG_AZ];
    wire       cont_mode = (conversion_mode_select == acc_pkg::ST_CONV);

    // Read data selection
    logic [23:0] rd_mux;
    always_comb begin
        unique case (l_adr)
            acc_pkg::ADR_RESULT: rd_mux = result_q;
            acc_pkg::ADR_MODE:   rd_mux = {22'h00_0000, adc_state_q};
            acc_pkg::ADR_CONFIG: rd_mux = {16'h0000, config_q};
            acc_pkg::ADR_OFFSET: rd_mux = offset_q;
            acc_pkg::ADR_GAIN:   rd_mux = gain_q;
            default:             rd_mux = 24'h00_0000; // Unmapped reads as zero
        endcase
    end

    // Synchronise pins; only the second stage feeds logic
    always_ff @(posedge i_clk) begin
        sy1_q  <= i_spi;
        sy2_q  <= sy1_q;
        sck3_q <= sy2_q.sck;
    end

    // Frame shifter: sample on rising edge, drive on falling edge
    always_ff @(posedge i_clk) begin
        if (i_srst || !cs_on) begin
            bit_cnt_q <= 6'h00;
            sh_in_q   <= 31'h0000_0000;
            sh_out_q  <= 24'h00_0000;
            sdo_q     <= 1'b0;
            sdo_oe_q  <= 1'b0;
        end else begin
            if (sck_rise && bit_cnt_q <= acc_pkg::FRAME_LAST) begin
                sh_in_q   <= {sh_in_q[29:0], sy2_q.sdi};
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            // Read data snapshot taken once the command is known
            if (cmd_at && l_cmd[1:0] == acc_pkg::CMD_RD) begin
                sh_out_q <= rd_mux;
                sdo_oe_q <= 1'b1;
            end else if (sck_fall && bit_cnt_q > acc_pkg::CMD_LAST) begin
                sdo_q    <= sh_out_q[23];
                sh_out_q <= {sh_out_q[22:0], 1'b0};
            end
        end
    end

    // ---------------- Conversion sequencer ----------------
    acc_pkg::acc_ctl_t ctl_q;
    logic [CNT_W-1:0]  conv_cnt_q;     // Cycles left in this conversion
    logic [8:0]        start_cnt_q;    // Remaining start-up wait
    logic              frst_q;         // Filter reset pulse

    wire samp    = (ctl_q == acc_pkg::CTL_CONV) && (conv_cnt_q == '0) && (adc_state_q == acc_pkg::ST_CONV);
    wire os_done = samp && !cont_mode;
    wire [CNT_W-1:0] first_len = az_on ? CONV_LEN2 : CONV_LEN; // R16 R21

    // Start-up timer: reset in shutdown, counts down otherwise
    always_ff @(posedge i_clk) begin
        if (i_srst || !adc_state_q[acc_pkg::ST_ON_BIT]) begin
            start_cnt_q <= acc_pkg::STARTUP_CYC;
        end else if (start_cnt_q != 9'h000) begin
            start_cnt_q <= start_cnt_q - 9'h001;
        end
    end

    // State field: host writes win; one-shot end falls back to idle code
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            adc_state_q <= acc_pkg::STATE_RST;
        end else if (wr_stb && f_adr == acc_pkg::ADR_MODE) begin
            adc_state_q <= f_dat[1:0];
        end else if (os_done) begin
            adc_state_q <= conversion_mode_select; // R13 R14 R22
        end
    end

    // Conversion timing; multiplier activity never stalls it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctl_q      <= acc_pkg::CTL_IDLE;
            conv_cnt_q <= '0;
            frst_q     <= 1'b0;
        end else begin
            frst_q <= 1'b0;
            unique case (ctl_q)
                acc_pkg::CTL_IDLE: begin
                    if (adc_state_q == acc_pkg::ST_CONV) begin
                        ctl_q <= acc_pkg::CTL_START;
                    end
                end
                acc_pkg::CTL_START: begin
                    if (adc_state_q != acc_pkg::ST_CONV) begin
                        ctl_q <= acc_pkg::CTL_IDLE;
                    end else if (start_cnt_q == 9'h000) begin
                        // Wait out start-up first, then a fresh filter
                        ctl_q      <= acc_pkg::CTL_CONV; // R17
                        conv_cnt_q <= first_len;         // R19
                        frst_q     <= 1'b1;
                    end
                end
                acc_pkg::CTL_CONV: begin
                    if (adc_state_q != acc_pkg::ST_CONV || os_done) begin
                        ctl_q <= acc_pkg::CTL_IDLE;      // R13 R14
                    end else if (samp && az_on) begin
                        // Chopping: restart each result from reset
                        conv_cnt_q <= CONV_LEN2;         // R21
                        frst_q     <= 1'b1;
                    end else if (samp) begin
                        // Filter never reset: moving average at data rate
                        conv_cnt_q <= DR_LEN;            // R15 R19 R20
                    end else begin
                        conv_cnt_q <= conv_cnt_q - CNT_W'(1);
                    end
                end
                default: ctl_q <= acc_pkg::CTL_IDLE;
            endcase
        end
    end

    // ---------------- Sample and offset ----------------
    // Corrections are captured at sample time, so register writes and
    // enable changes only affect results sampled afterwards.
    wire signed [24:0] off_term = config_q[acc_pkg::CFG_OFF_EN] ? $signed({offset_q[23], offset_q}) : 25'sh000_0000; // R12
    wire signed [24:0] raw_x    = $signed({i_raw_code[23], i_raw_code});
    acc_pkg::acc_word_t samp_w;
    assign samp_w.sum     = raw_x + off_term;                 // R01 R04
    assign samp_w.gain_en = config_q[acc_pkg::CFG_GAIN_EN];   // R10 R12
    assign samp_w.gain    = gain_q;                           // R11

    acc_pkg::acc_word_t pend_q;        // Sample waiting for buffer room
    logic               pend_v_q;

    // ---------------- Two-entry buffer ----------------
    acc_pkg::acc_word_t fifo_q [FIFO_DEPTH];
    logic [PW-1:0]      wp_q;
    logic [PW-1:0]      rp_q;
    logic [PW:0]        cnt_q;
    logic               mul_busy_q;

    wire in_rdy  = (cnt_q != FIFO_FULL);
    wire push    = pend_v_q && in_rdy;
    wire out_vld = (cnt_q != '0);
    wire pop     = out_vld && !mul_busy_q;
    acc_pkg::acc_word_t head;
    assign head = fifo_q[rp_q];

    // Pending sample holds until the buffer accepts it or the next sample overwrites it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pend_v_q <= 1'b0;
            pend_q   <= '0;
        end else if (samp) begin
            pend_v_q <= 1'b1;          // R05 R06 R10 R11
            pend_q   <= samp_w;
        end else if (push) begin
            pend_v_q <= 1'b0;
        end
    end

    // Buffer storage and pointers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                fifo_q[wp_q] <= pend_q;
                wp_q         <= (wp_q == PTR_LAST) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == PTR_LAST) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

    // ---------------- Gain multiplier ----------------
    logic signed [48:0] mul_acc_q;     // Running partial sum, full precision
    logic signed [48:0] mul_mc_q;      // Shifted multiplicand
    logic [22:0]        mul_mp_q;      // Remaining gain bits
    logic [4:0]         mul_cnt_q;

    wire signed [48:0] head_x  = 49'(head.sum);
    wire signed [48:0] step    = mul_mp_q[0] ? mul_mc_q : 49'sh0;
    wire signed [48:0] acc_nx  = mul_acc_q + step;
    wire               mul_end = mul_busy_q && (mul_cnt_q == acc_pkg::GCAL_CYC - 5'h01);
    wire               res_wr  = (pop && !head.gain_en) || mul_end;
    // Clamp only the final value; guard bits absorb interim overflow
    wire [23:0] res_val = mul_end ? acc_pkg::acc_clamp(acc_nx >>> acc_pkg::GAIN_FRAC) // R02 R07 R23
                                  : acc_pkg::acc_clamp(head_x);                       // R02 R23

    // One gain bit per cycle; the pop cycle handles bit zero
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mul_busy_q <= 1'b0;
            mul_acc_q  <= '0;
            mul_mc_q   <= '0;
            mul_mp_q   <= '0;
            mul_cnt_q  <= '0;
        end else if (pop && head.gain_en) begin
            mul_busy_q <= 1'b1;        // R08 R09
            mul_acc_q  <= head.gain[0] ? head_x : 49'sh0;
            mul_mc_q   <= head_x <<< 1;
            mul_mp_q   <= head.gain[23:1];
            mul_cnt_q  <= '0;
        end else if (mul_busy_q) begin
            mul_acc_q  <= acc_nx;
            mul_mc_q   <= mul_mc_q <<< 1;
            mul_mp_q   <= {1'b0, mul_mp_q[22:1]};
            mul_cnt_q  <= mul_cnt_q + 5'h01;
            mul_busy_q <= !mul_end;    // R08
        end
    end

    // ---------------- Register writes ----------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            result_q <= 24'h00_0000;
            offset_q <= acc_pkg::OFFSET_RST;
            gain_q   <= acc_pkg::GAIN_RST;
            config_q <= acc_pkg::CONFIG_RST;
        end else begin
            if (res_wr) begin
                result_q <= res_val;   // R01
            end
            if (wr_stb && f_adr == acc_pkg::ADR_OFFSET) begin
                offset_q <= f_dat;     // R03 R06
            end
            if (wr_stb && f_adr == acc_pkg::ADR_GAIN) begin
                gain_q <= f_dat;       // R07 R11
            end
            if (wr_stb && f_adr == acc_pkg::ADR_CONFIG) begin
                config_q <= f_dat[7:0];
            end
        end
    end

    // ---------------- Data-ready output ----------------
    logic             irq_n_q;
    logic [CNT_W-1:0] hold_q;

    // New data wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            irq_n_q <= 1'b1;
            hold_q  <= '0;
        end else if (res_wr) begin
            irq_n_q <= 1'b0;
            hold_q  <= HOLD_LEN;
        end else if (rd_done) begin
            irq_n_q <= 1'b1;           // R18
        end else if (cont_mode && !irq_n_q) begin
            // Continuous mode releases the line by itself
            irq_n_q <= (hold_q == '0); // R18
            hold_q  <= hold_q - CNT_W'(1);
        end
    end

    assign o_sdo        = sdo_q;
    assign o_sdo_oe     = sdo_oe_q;
    assign o_irq_n      = irq_n_q;
    assign o_filter_rst = frst_q;
    assign o_adc_state  = adc_state_q;

endmodule

// ===== src/acc_pkg.sv
// Function
// [R01] Result equals raw plus offset, times gain
// [R02] Guard bits kept; overload judged only at end
// [R03] Offset register: signed 24 bits, address 0x9
// [R04] Offset added by plain adder, no latency
// [R05] Offset enable affects only the next result
// [R06] New offset value affects only next result
// [R07] Gain register 0xA: unsigned code over 2^23
// [R08] Gain shift-add multiplier adds 23 cycles delay
// [R09] Conversions continue while multiplier runs
// [R10] Gain enable affects only the next result
// [R11] New gain value affects only next result
// [R12] Disabled correction skipped, register ignored
// [R13] Mode 0x: one conversion, then shutdown
// [R14] Mode 10: one conversion, then standby
// [R15] Mode 11: continuous, state stays 11
// [R16] One-shot lasts one or two conversion times
// [R17] One-shot waits remaining start-up time first
// [R18] One-shot interrupt held until result fully read
// [R19] Continuous: first after conversion time, then data rate
// [R20] Each continuous event is a complete conversion
// [R21] Chopping continuous: restart, double group delay
// [R22] State 11 convert, 10 standby, 0x shutdown
// [R23] Out-of-range final result clamps to full scale
package acc_pkg;

    // Register addresses (4-bit command field)
    localparam logic [3:0]  ADR_RESULT = 4'h0;
    localparam logic [3:0]  ADR_MODE   = 4'h1;
    localparam logic [3:0]  ADR_CONFIG = 4'h3;
    localparam logic [3:0]  ADR_OFFSET = 4'h9;
    localparam logic [3:0]  ADR_GAIN   = 4'hA;
    // Command type in the low two command bits
    localparam logic [1:0]  CMD_WR     = 2'h2;
    localparam logic [1:0]  CMD_RD     = 2'h3;
    localparam int          CMD_ADR_LSB = 2;
    localparam logic [5:0]  CMD_LAST   = 6'h07;
    localparam logic [5:0]  FRAME_LAST = 6'h1F;
    // Config word three field positions
    localparam int          CFG_GAIN_EN = 0;
    localparam int          CFG_OFF_EN  = 1;
    localparam int          CFG_AZ      = 2;
    localparam int          CFG_CMODE   = 6;
    localparam int          ST_ON_BIT   = 1;
    // Converter state codes
    localparam logic [1:0]  ST_CONV     = 2'h3;
    // Reset values
    localparam logic [23:0] OFFSET_RST = 24'h00_0000;
    localparam logic [23:0] GAIN_RST   = 24'h80_0000;
    localparam logic [7:0]  CONFIG_RST = 8'h00;
    localparam logic [1:0]  STATE_RST  = 2'h0;
    // Timing in decimation clock periods
    localparam logic [8:0]  STARTUP_CYC = 9'h100;
    localparam logic [4:0]  GCAL_CYC    = 5'h17;
    localparam int          GAIN_FRAC   = 23;
    // Full-scale output codes
    localparam logic signed [48:0] POS_FS = 49'sh0_0000_007F_FFFF;
    localparam logic signed [48:0] NEG_FS = -49'sh0_0000_0080_0000;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic sdi;
    } acc_spi_t;

    typedef struct packed {
        logic signed [24:0] sum;
        logic               gain_en;
        logic [23:0]        gain;
    } acc_word_t;

    typedef enum logic [1:0] {
        CTL_IDLE  = 2'b00,
        CTL_START = 2'b01,
        CTL_CONV  = 2'b10
    } acc_ctl_t;

    // Saturate a wide corrected value to the 24-bit output range
    function automatic logic [23:0] acc_clamp(input logic signed [48:0] v);
        logic [23:0] r;
        r = v[23:0];
        if (v > POS_FS) begin
            r = POS_FS[23:0];
        end else if (v < NEG_FS) begin
            r = NEG_FS[23:0];
        end
        return r;
    endfunction

endpackage

// ===== tb/acc_core_checker.sv
`timescale 1ns/1ps
// Pin-level watch on the converter back end
module acc_core_checker #(
    parameter int CONV_CYC = 1024, // Conversion time in clock periods
    parameter int IRQ_HOLD = 32    // Continuous interrupt auto-clear delay
) (
    input wire logic              i_clk,
    input wire logic              i_srst,
    input wire acc_pkg::acc_spi_t i_spi,
    input wire logic [23:0]       i_raw_code,
    input wire logic              o_sdo,
    input wire logic              o_sdo_oe,
    input wire logic              o_irq_n,
    input wire logic              o_filter_rst,
    input wire logic [1:0]        o_adc_state
);
    localparam int HOLD_MAX = IRQ_HOLD + 3;  // Clear delay plus register slack
    localparam int TWO_CONV = 2 * CONV_CYC;  // Chopped conversion length
    localparam int LEN_LO   = CONV_CYC - 1;  // Sample edge may land one cycle early or two cycles late
    localparam int LEN_HI   = CONV_CYC + 2;
    localparam int LEN2_LO  = TWO_CONV - 1;
    localparam int LEN2_HI  = TWO_CONV + 2;
    logic [15:0] since_q; // Cycles since the last filter reset pulse
    logic [15:0] since_d; // Saturates, so a long idle never wraps into a false window
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    assign since_d = o_filter_rst ? 16'h0001 : ((since_q == 16'hFFFF) ? since_q : since_q + 16'h0001);
    // Conversion age counter
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            since_q <= 16'h0000;
        end else begin
            since_q <= since_d;
        end
    end
    AST_RST_IDLE: assert property ($fell(i_srst) |-> (o_irq_n && !o_sdo_oe && !o_filter_rst && o_adc_state == 2'b00))
        else $error("outputs not idle after reset");
    AST_FRST_SPACING: assert property (o_filter_rst |-> (since_q == 16'h0000 || since_q >= TWO_CONV))
        else $error("filter reset too soon after previous one");
    AST_FRST_CONV: assert property (o_filter_rst |-> o_adc_state == 2'b11)
        else $error("filter reset outside conversion state");
    AST_ONESHOT_LEN: assert property (($past(o_adc_state) == 2'b11 && o_adc_state != 2'b11)
        |-> (since_q inside {[LEN_LO:LEN_HI], [LEN2_LO:LEN2_HI]}))
        else $error("one-shot length wrong");
    AST_IRQ_AFTER_CONV: assert property (($fell(o_irq_n) && o_adc_state != 2'b11) |-> since_q >= CONV_CYC)
        else $error("data ready before conversion complete");
    AST_ONESHOT_HOLD: assert property ((!o_irq_n && o_adc_state != 2'b11 && i_spi.cs_n) |=> !o_irq_n)
        else $error("one-shot interrupt cleared without read");
    AST_CONT_CLEAR: assert property (($fell(o_irq_n) && o_adc_state == 2'b11) |-> ##[1:HOLD_MAX] o_irq_n)
        else $error("continuous interrupt not cleared");
    AST_IDLE_HOLD: assert property ((o_adc_state != 2'b11 && i_spi.cs_n) |=> o_adc_state == $past(o_adc_state))
        else $error("idle state changed without host");
    cover property (o_filter_rst);
    cover property ($fell(o_irq_n) && o_adc_state == 2'b11);
    cover property ($rose(o_sdo_oe));
endmodule

bind acc_core acc_core_checker #(.CONV_CYC(CONV_CYC), .IRQ_HOLD(IRQ_HOLD)) acc_core_checker_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_spi(i_spi), .i_raw_code(i_raw_code), .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe), .o_irq_n(o_irq_n), .o_filter_rst(o_filter_rst), .o_adc_state(o_adc_state));

// ===== tb/acc_core_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the converter back end
module acc_core_tb;
    localparam int CONV = 20;   // Shortened conversion time
    localparam int DR   = 8;    // Shortened data rate period
    localparam int LIM  = 4000; // Bound on every wait
    logic              i_clk;        // Decimation clock
    logic              i_srst;       // Synchronous reset
    acc_pkg::acc_spi_t i_spi;        // Serial pins from the host model
    logic [23:0]       i_raw_code;   // Raw filter code
    logic              o_sdo;
    logic              o_sdo_oe;
    logic              o_irq_n;
    logic              o_filter_rst;
    logic [1:0]        o_adc_state;
    int                n_errors;
    int                samples_checked;

    acc_core #(.CONV_CYC(CONV), .DR_CYC(DR), .IRQ_HOLD(4), .FIFO_DEPTH(2), .CNT_W(16)) acc_core_inst (
        .i_clk(i_clk), .i_srst(i_srst), .i_spi(i_spi), .i_raw_code(i_raw_code), .o_sdo(o_sdo),
        .o_sdo_oe(o_sdo_oe), .o_irq_n(o_irq_n), .o_filter_rst(o_filter_rst), .o_adc_state(o_adc_state));
    acc_host_model acc_host_model_inst (.i_clk(i_clk), .i_sdo(o_sdo), .o_spi(i_spi));

    // 50 MHz clock
    always #10 i_clk = ~i_clk;

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] adr, input logic [23:0] d);
        logic [23:0] unused;
        acc_host_model_inst.frame({2'b00, adr, acc_pkg::CMD_WR}, d, unused);
    endtask

    task automatic rd(input logic [3:0] adr, output logic [23:0] d);
        acc_host_model_inst.frame({2'b00, adr, acc_pkg::CMD_RD}, 24'h00_0000, d);
    endtask

    // Cycles until data ready reaches a level; a hang ends the run
    task automatic wait_irq(input logic lvl, output int n);
        n = 0;
        while (o_irq_n !== lvl && n < LIM) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= LIM) begin
            n_errors++;
            $display("wrong value irq wait expected %b seen timeout", lvl);
            summarize();
        end
    endtask

    task automatic do_reset();
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_srst <= 1'b0;
    endtask

    // Start one conversion, return cycles from the start write to data ready
    task automatic oneshot(input logic [23:0] raw, input logic [7:0] cfg, input logic [23:0] exp, output int lat);
        logic [23:0] r;
        @(posedge i_clk);
        i_raw_code <= raw;
        wr(acc_pkg::ADR_CONFIG, {16'h0000, cfg});
        wr(acc_pkg::ADR_MODE, 24'h00_0003);
        wait_irq(1'b0, lat);
        check("idle_state", {22'h0, o_adc_state}, {22'h0, cfg[7:6]});
        rd(acc_pkg::ADR_RESULT, r);
        check("result", r, exp);
        check("irq_cleared", {23'h0, o_irq_n}, 24'h00_0001);
        check("sdo_released", {23'h0, o_sdo_oe}, 24'h00_0000);
    endtask

    task automatic t_regs();
        logic [23:0] r;
        do_reset();
        rd(acc_pkg::ADR_OFFSET, r);
        check("offset_reset", r, 24'h00_0000);
        rd(acc_pkg::ADR_GAIN, r);
        check("gain_reset", r, 24'h80_0000);
        wr(acc_pkg::ADR_OFFSET, 24'hA5_5A3C);
        rd(acc_pkg::ADR_OFFSET, r);
        check("offset_rw", r, 24'hA5_5A3C);
        wr(acc_pkg::ADR_GAIN, 24'h12_3456);
        rd(acc_pkg::ADR_GAIN, r);
        check("gain_rw", r, 24'h12_3456);
        wr(acc_pkg::ADR_RESULT, 24'hFF_FFFF);
        rd(acc_pkg::ADR_RESULT, r);
        check("result_ro", r, 24'h00_0000);
        wr(4'h5, 24'h00_1234);
        rd(4'h5, r);
        check("unmapped", r, 24'h00_0000);
    endtask

    task automatic t_oneshot();
        int l0;
        int l1;
        int l2;
        logic [23:0] r;
        do_reset();
        oneshot(24'h00_0123, 8'h80, 24'h00_0123, l0);
        check("startup_wait", 24'(l0 >= 256), 24'h00_0001);
        wr(acc_pkg::ADR_OFFSET, 24'h10_0000);
        oneshot(24'h00_0123, 8'h80, 24'h00_0123, l1);
        check("standby_start", 24'(l1 < 2 * CONV), 24'h00_0001);
        wr(acc_pkg::ADR_CONFIG, 24'h00_0082);
        rd(acc_pkg::ADR_RESULT, r);
        check("held_enable", r, 24'h00_0123);
        wr(acc_pkg::ADR_OFFSET, 24'h00_0020);
        rd(acc_pkg::ADR_RESULT, r);
        check("held_offset", r, 24'h00_0123);
        oneshot(24'h00_0123, 8'h82, 24'h00_0143, l2);
        check("offset_latency", 24'(l2), 24'(l1));
        // Sum overflows 24 bits but halving brings it back in range
        wr(acc_pkg::ADR_OFFSET, 24'h10_0000);
        wr(acc_pkg::ADR_GAIN, 24'h40_0000);
        oneshot(24'h7F_FFFF, 8'h83, 24'h47_FFFF, l2);
        check("gain_latency", 24'(l2), 24'(l1 + 23));
        wr(acc_pkg::ADR_GAIN, 24'hC0_0000);
        oneshot(24'h70_0000, 8'h83, 24'h7F_FFFF, l2);
        // Chopped one-shot with return to shutdown and negative clamp
        wr(acc_pkg::ADR_OFFSET, 24'hFF_FFFF);
        oneshot(24'h90_0000, 8'h07, 24'h80_0000, l2);
        check("chop_length", 24'(l2), 24'(l1 + CONV + 23));
    endtask

    task automatic t_cont();
        int n;
        int g;
        logic [23:0] r;
        do_reset();
        i_raw_code <= 24'h00_0055;
        wr(acc_pkg::ADR_CONFIG, 24'h00_00C0);
        wr(acc_pkg::ADR_MODE, 24'h00_0003);
        wait_irq(1'b0, n);
        wait_irq(1'b1, n);
        wait_irq(1'b0, g);
        check("cont_gap", 24'(n + g), 24'(DR));
        check("cont_state", {22'h0, o_adc_state}, 24'h00_0003);
        rd(acc_pkg::ADR_RESULT, r);
        check("cont_data", r, 24'h00_0055);
        // Chopping with the gain pipeline running must keep the pace
        do_reset();
        wr(acc_pkg::ADR_CONFIG, 24'h00_00C5);
        wr(acc_pkg::ADR_MODE, 24'h00_0003);
        wait_irq(1'b0, n);
        wait_irq(1'b1, n);
        wait_irq(1'b0, g);
        check("chop_gap", 24'(n + g), 24'(2 * CONV));
    endtask

    // Main sequence
    initial begin
        i_clk = 1'b0;
        i_srst = 1'b1;
        i_raw_code = 24'h00_0000;
        n_errors = 0;
        samples_checked = 0;
        t_regs();
        t_oneshot();
        t_cont();
        summarize();
    end
endmodule

// ===== tb/acc_host_model.sv
`timescale 1ns/1ps
// Host side of the serial port: mode 0 master, one 32-bit frame per call
module acc_host_model #(
    parameter int HALF = 5 // Clocks per half bit, above the 4-cycle minimum
) (
    input  wire logic         i_clk,
    input  wire logic         i_sdo,
    output acc_pkg::acc_spi_t o_spi
);
    // Deselected and clock parked low at time zero
    initial o_spi = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};

    // Full frame always, so a result read is complete and can clear data ready
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wdata, output logic [23:0] rdata);
        logic [31:0] sh;
        sh = {cmd, wdata};
        rdata = 24'h00_0000;
        @(posedge i_clk);
        o_spi.cs_n <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            o_spi.sdi <= sh[i];
            repeat (HALF) @(posedge i_clk);
            o_spi.sck <= 1'b1;
            // Read bits are settled well before the rising clock
            if (i < 24) begin
                rdata = {rdata[22:0], i_sdo};
            end
            repeat (HALF) @(posedge i_clk);
            o_spi.sck <= 1'b0;
        end
        repeat (HALF) @(posedge i_clk);
        o_spi.cs_n <= 1'b1;
        // Released data line must not keep its last level
        o_spi.sdi <= ~o_spi.sdi;
        repeat (HALF) @(posedge i_clk);
    endtask
endmodule
